//--- rtl/ckmux_map.svh
// Constants of the clock selector, gate and fanout
`ifndef CKMUX_MAP_SVH
`define CKMUX_MAP_SVH

// Number of differential output pairs
`define CKMUX_FANOUT_NUM 4
// Synchronised pin vector layout
`define CKMUX_PIN_W 6
`define CKMUX_PIN_PRI_P 0
`define CKMUX_PIN_PRI_N 1
`define CKMUX_PIN_SEC_P 2
`define CKMUX_PIN_SEC_N 3
`define CKMUX_PIN_EN 4
`define CKMUX_PIN_SEL 5
// Open-pin levels: true inputs pulled down, complements and enable up
`define CKMUX_PIN_RST 6'h1a
// Gate sequencer state codes
`define CKMUX_ST_IDLE 3'h1
`define CKMUX_ST_RISE 3'h2
`define CKMUX_ST_FALL 3'h4

`endif

//--- rtl/ckmux_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module ckmux_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Pin side
  input wire logic [WIDTH-1:0] i_async,
  // Clean side
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;

  // A change is taken only once stages two and three agree
  assign out_next = (s2_reg & s3_reg) | (out_reg & (s2_reg | s3_reg));
  assign o_sync = out_reg;

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
      out_reg <= RESET_VAL;
    end else if (i_ce) begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end
endmodule

//--- rtl/ckmux_pkg.sv
// Types of the clock selector, gate and fanout
package ckmux_pkg;
  `include "ckmux_map.svh"

  typedef enum logic [2:0] {
    CKMUX_ST_IDLE = `CKMUX_ST_IDLE,
    CKMUX_ST_RISE = `CKMUX_ST_RISE,
    CKMUX_ST_FALL = `CKMUX_ST_FALL
  } ckmux_state_e;
endpackage

//--- rtl/ckmux_top.sv
// Two-to-one clock selector with synchronous gate and four-way fanout
`timescale 1ns/10ps
`include "ckmux_map.svh"
module ckmux_top
  import ckmux_pkg::*;
#(
  parameter int FANOUT_NUM = `CKMUX_FANOUT_NUM
) (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Primary differential clock
  input wire logic i_pri_clk_p,
  input wire logic i_pri_clk_n,
  // Secondary differential clock
  input wire logic i_sec_clk_p,
  input wire logic i_sec_clk_n,
  // Controls
  input wire logic i_clk_sel,
  input wire logic i_clk_en,
  // Fanout outputs
  output logic [FANOUT_NUM-1:0] o_fanout_out_p,
  output logic [FANOUT_NUM-1:0] o_fanout_out_n
);
  logic [`CKMUX_PIN_W-1:0] pin_raw;
  logic [`CKMUX_PIN_W-1:0] pin_f;
  logic sel_f;
  logic en_f;
  logic pri_lvl_reg;
  logic pri_lvl_next;
  logic sec_lvl_reg;
  logic sec_lvl_next;
  logic sel_lvl;
  logic lvl_prev_reg;
  logic clk_rise;
  logic clk_fall;
  logic gate_reg;
  logic gate_next;
  logic gate_apply;
  ckmux_state_e state_reg;
  ckmux_state_e state_next;

  // Equal legs (mid-swing) hold the last level; open legs read low
  function automatic logic diff_level(input logic p, input logic n, input logic prev);
    diff_level = (p != n) ? p : prev;
  endfunction

  assign pin_raw = {i_clk_sel, i_clk_en, i_sec_clk_n, i_sec_clk_p, i_pri_clk_n, i_pri_clk_p};

  // Reset value stands for the pull resistors on open pins
  ckmux_pin_sync #(
    .WIDTH(`CKMUX_PIN_W),
    .RESET_VAL(`CKMUX_PIN_RST)
  ) u_pin_sync (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_async(pin_raw),
    .o_sync(pin_f)
  );

  assign sel_f = pin_f[`CKMUX_PIN_SEL];
  assign en_f = pin_f[`CKMUX_PIN_EN];
  assign pri_lvl_next = diff_level(pin_f[`CKMUX_PIN_PRI_P], pin_f[`CKMUX_PIN_PRI_N], pri_lvl_reg);
  assign sec_lvl_next = diff_level(pin_f[`CKMUX_PIN_SEC_P], pin_f[`CKMUX_PIN_SEC_N], sec_lvl_reg);

  // Select is meant to be static; switching it live may cut a pulse
  assign sel_lvl = sel_f ? sec_lvl_reg : pri_lvl_reg;
  assign clk_rise = sel_lvl & ~lvl_prev_reg;
  assign clk_fall = ~sel_lvl & lvl_prev_reg;

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      pri_lvl_reg <= 1'b0;
      sec_lvl_reg <= 1'b0;
      lvl_prev_reg <= 1'b0;
    end else if (i_ce) begin
      pri_lvl_reg <= pri_lvl_next;
      sec_lvl_reg <= sec_lvl_next;
      lvl_prev_reg <= sel_lvl;
    end
  end

  // Gate sequencer: arm on a request, then wait for a rise and a fall
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CKMUX_ST_IDLE: begin
        if (en_f != gate_reg) begin
          state_next = CKMUX_ST_RISE;
        end
      end
      CKMUX_ST_RISE: begin
        if (en_f == gate_reg) begin
          state_next = CKMUX_ST_IDLE;
        end else if (clk_rise) begin
          state_next = CKMUX_ST_FALL;
        end
      end
      CKMUX_ST_FALL: begin
        if (en_f == gate_reg) begin
          state_next = CKMUX_ST_IDLE;
        end else if (clk_fall) begin
          state_next = CKMUX_ST_IDLE;
        end
      end
      default: begin
        state_next = CKMUX_ST_IDLE;
      end
    endcase
  end

  // Enable sampled only at a falling edge, when the clock is low
  assign gate_apply = (state_reg == CKMUX_ST_FALL) && clk_fall;
  assign gate_next = gate_apply ? en_f : gate_reg;

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      state_reg <= CKMUX_ST_IDLE;
      gate_reg <= 1'b1;
    end else if (i_ce) begin
      state_reg <= state_next;
      gate_reg <= gate_next;
    end
  end

  // One flop per leg keeps the pairs identical and registered
  genvar gi;
  generate
    for (gi = 0; gi < FANOUT_NUM; gi++) begin : g_fanout
      logic out_p_reg;
      logic out_n_reg;
      always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
          out_p_reg <= 1'b0;
          out_n_reg <= 1'b1;
        end else if (i_ce) begin
          out_p_reg <= gate_next & sel_lvl;
          out_n_reg <= ~(gate_next & sel_lvl);
        end
      end
      assign o_fanout_out_p[gi] = out_p_reg;
      assign o_fanout_out_n[gi] = out_n_reg;
    end
  endgenerate

  default clocking cb_mclk @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_arm;
    state_reg == CKMUX_ST_IDLE && i_ce && en_f != gate_reg;
  endsequence

  sequence s_rise_then_fall;
    state_reg == CKMUX_ST_RISE ##[1:1000] state_reg == CKMUX_ST_FALL;
  endsequence

  a_pri_route:
  assert property (gate_reg && !sel_f && i_ce
                   |=> o_fanout_out_p == {FANOUT_NUM{$past(pri_lvl_reg)}})
    else $error("primary clock not routed");

  a_sec_route:
  assert property (gate_reg && sel_f && i_ce
                   |=> o_fanout_out_p == {FANOUT_NUM{$past(sec_lvl_reg)}})
    else $error("secondary clock not routed");

  // Watched across reset itself, so the default disable is lifted here
  a_open_select:
  assert property (@(posedge i_mclk) disable iff (1'b0)
                   !i_resetn |=> !sel_f && sel_lvl == pri_lvl_reg)
    else $error("open select not low");

  a_open_enable:
  assert property (@(posedge i_mclk) disable iff (1'b0)
                   !i_resetn |=> en_f && gate_reg)
    else $error("open enable not high");

  a_change_low:
  assert property ($changed(gate_reg) |-> o_fanout_out_p == '0 && !$past(sel_lvl))
    else $error("gate changed while clock high");

  a_fall_capture:
  assert property ($changed(gate_reg) |-> $past(clk_fall) && gate_reg == $past(en_f))
    else $error("gate not taken on falling edge");

  a_gate_high:
  assert property (gate_reg && sel_lvl && i_ce |=> o_fanout_out_p == '1 && o_fanout_out_n == '0)
    else $error("enabled output not following clock");

  a_gate_low:
  assert property (!$past(gate_reg) |-> o_fanout_out_p == '0 && o_fanout_out_n == '1)
    else $error("disabled output not parked");

  a_arm_rise:
  assert property (s_arm |=> state_reg == CKMUX_ST_RISE)
    else $error("gate request not armed");

  a_rise_fall_order:
  assert property ($changed(gate_reg) |-> $past(state_reg == CKMUX_ST_FALL))
    else $error("gate changed without rise and fall");

  a_rise_seen:
  assert property (state_reg == CKMUX_ST_FALL |-> $past(state_reg == CKMUX_ST_FALL)
                   || $past(clk_rise) || !$past(i_ce))
    else $error("fall wait entered without rise");

  a_pairs_equal:
  assert property (o_fanout_out_p == {FANOUT_NUM{o_fanout_out_p[0]}}
                   && o_fanout_out_n == ~o_fanout_out_p)
    else $error("output pairs differ");
endmodule

//--- verification/ckmux_src_model.sv
// Behavioural model of the two differential clock sources
`timescale 1ns/10ps
module ckmux_src_model (
  // Timing
  input wire logic i_mclk,
  input wire logic [7:0] i_pri_half,
  input wire logic [7:0] i_sec_half,
  // Differential clocks
  output logic o_pri_p,
  output logic o_pri_n,
  output logic o_sec_p,
  output logic o_sec_n
);
  logic [7:0] pri_cnt_reg = 8'h00;
  logic [7:0] sec_cnt_reg = 8'h00;
  initial begin
    o_pri_p = 1'b0;
    o_pri_n = 1'b1;
    o_sec_p = 1'b0;
    o_sec_n = 1'b1;
  end
  // Legs always opposite, so the decoder never holds
  always @(negedge i_mclk) begin
    pri_cnt_reg <= (pri_cnt_reg + 8'h01 >= i_pri_half) ? 8'h00 : pri_cnt_reg + 8'h01;
    if (pri_cnt_reg + 8'h01 >= i_pri_half) begin
      o_pri_p <= ~o_pri_p;
      o_pri_n <= o_pri_p;
    end
    sec_cnt_reg <= (sec_cnt_reg + 8'h01 >= i_sec_half) ? 8'h00 : sec_cnt_reg + 8'h01;
    if (sec_cnt_reg + 8'h01 >= i_sec_half) begin
      o_sec_p <= ~o_sec_p;
      o_sec_n <= o_sec_p;
    end
  end
endmodule

//--- verification/tb.sv
// Self-checking bench of the clock selector, gate and fanout
`timescale 1ns/10ps
module tb;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_clk_sel = 1'b0;
  logic i_clk_en = 1'b1;
  logic i_ce = 1'b1;
  logic [3:0] hold_p;
  logic pri_p, pri_n, sec_p, sec_n;
  logic [7:0] pri_half = 8'h06;
  logic [7:0] sec_half = 8'h09;
  logic [3:0] out_p, out_n;
  int n_fail = 0;
  int checks_done = 0;
  int hi_cnt = 0;
  int n_pulse = 0;
  bit mon_on = 1'b0;

  initial begin
    forever #12.5 i_mclk = ~i_mclk;
  end

  ckmux_src_model u_ckmux_src_model (.i_mclk(i_mclk), .i_pri_half(pri_half),
    .i_sec_half(sec_half), .o_pri_p(pri_p), .o_pri_n(pri_n), .o_sec_p(sec_p),
    .o_sec_n(sec_n));

  ckmux_top u_ckmux_top (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(i_ce),
    .i_pri_clk_p(pri_p), .i_pri_clk_n(pri_n), .i_sec_clk_p(sec_p), .i_sec_clk_n(sec_n),
    .i_clk_sel(i_clk_sel), .i_clk_en(i_clk_en), .o_fanout_out_p(out_p),
    .o_fanout_out_n(out_n));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] exp_half(input logic sel);
    return sel ? {24'h0, sec_half} : {24'h0, pri_half};
  endfunction

  task automatic close_out;
    $display("TB checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge i_mclk);
  endtask

  // Outputs held off, several cycles past any pending gate change
  task automatic off_check;
    repeat (20) begin
      @(negedge i_mclk);
      check("off_p", {28'h0, out_p}, 32'h0);
      check("off_n", {28'h0, out_n}, 32'hf);
    end
  endtask

  // Pulse widths catch runts at gate changes and the wrong source
  always @(negedge i_mclk) begin
    if (mon_on) begin
      check("pair", {28'h0, out_n}, {28'h0, ~out_p});
      check("fanout", {28'h0, out_p}, {28'h0, {4{out_p[0]}}});
      if (out_p[0] === 1'b1) begin
        if (hi_cnt == 0) n_pulse++;
        hi_cnt++;
      end else begin
        if (hi_cnt != 0) check("width", hi_cnt, exp_half(i_clk_sel));
        hi_cnt = 0;
      end
    end
  end

  initial begin
    #200000;
    n_fail++;
    close_out;
  end

  initial begin
    void'($urandom(30196));
    wait_n(4);
    check("rst_p", {28'h0, out_p}, 32'h0);
    wait_n(1);
    i_resetn = 1'b1;
    mon_on = 1'b1;
    // Pull levels on select and gate: primary, enabled
    wait_n(150);
    check("open_pins", {31'h0, n_pulse != 0}, 32'h1);
    $display("TB test open pins done");
    for (int k = 0; k < 8; k++) begin
      i_clk_en = 1'b0;
      wait_n(70);
      off_check;
      hi_cnt = 0;
      mon_on = 1'b1;
      pri_half <= 8'h04 + 8'($urandom % 8);
      sec_half <= 8'h0c + 8'($urandom % 4);
      i_clk_sel = (k < 2) ? k[0] : 1'($urandom % 2);
      wait_n(10);
      n_pulse = 0;
      i_clk_en = 1'b1;
      wait_n(100 + $urandom % 100);
      check("pulses", {31'h0, n_pulse != 0}, 32'h1);
      // Enable low freezes the outputs mid-pulse; widths are void until off
      mon_on = 1'b0;
      hold_p = out_p;
      i_ce = 1'b0;
      repeat (12) begin
        @(negedge i_mclk);
        check("hold_p", {28'h0, out_p}, {28'h0, hold_p});
        check("hold_n", {28'h0, out_n}, {28'h0, ~hold_p});
      end
      i_ce = 1'b1;
      $display("TB test %0d sel %0d done", k, i_clk_sel);
    end
    close_out;
  end
endmodule
